// file: rtl/i2ccw_control_word.sv
// i2c control word register with software pin control, role and receive-response outputs
// assumes pins are external open-drain lines; scl/sda inputs are asynchronous and synchronised here;
// the protocol controller supplies its own pin drives and byte/address event pulses on this clock
// Behaviour
// - bit 8 reads synchronised scl level
// - bit 7 drives sda under software control
// - bit 6 drives scl under software control
// - bit 4 selects ack or nack response
// - bit 3 enables per-byte interrupt, then respond
// - bit 2 acknowledges general call address
// - bit 1 selects master or slave
// - bit 0 enables peripheral, reset disabled
// - swoe hands pins to software bits
module i2ccw_control_word
    import i2ccw_pkg::*;
(
    input wire logic clock, // 125 MHz
    input wire logic reset, // sync, active high
    input wire i2ccw_bus_s bus, // register port request
    output logic [31:0] rdata, // read data, cycle after read
    input wire logic sclIn, // scl pin level
    input wire logic sdaIn, // sda pin level
    input wire i2ccw_pins_s ctlPins, // protocol controller pin drive
    input wire logic rxByteDone, // controller received a data byte
    input wire logic addrSeen, // controller saw an address byte
    input wire logic [7:0] addrByte, // address byte seen
    output i2ccw_pins_s pins, // pin drives to pads
    output logic periphEnable, // peripheral enable
    output logic masterMode, // 1 master, 0 slave
    output logic addrAck, // acknowledge seen general call address
    output logic rxNack, // response for received byte
    output logic rxRespValid, // response valid pulse
    output logic sclLevel, // synchronised scl level
    output logic sdaLevel, // synchronised sda level
    output logic irq // level interrupt
);

    logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [EV_W-1:0] status_ff, nxt_status;
    logic [EV_W-1:0] ien_ff;
    logic sclMeta_ff, sclSync_ff, sclPrev_ff;
    logic sdaMeta_ff, sdaSync_ff;
    logic [31:0] rdata_ff;
    logic irq_ff;
    i2ccw_pins_s pins_ff;
    logic addrAck_ff, rxNack_ff, rxRespValid_ff;
    logic rxPending_ff;

    wire logic selCtrl = bus.addr == OFF_CONTROL_MAIN;
    wire logic selStat = bus.addr == OFF_IRQ_STATUS;
    wire logic selClr = bus.addr == OFF_IRQ_CLEAR;
    wire logic selIen = bus.addr == OFF_IRQ_ENABLE;
    wire logic selRx = bus.addr == OFF_RX_CTRL;
    wire logic wrCtrl = bus.wr && selCtrl;
    wire logic wrClr = bus.wr && selClr;
    wire logic wrIen = bus.wr && selIen;
    wire logic wrRx = bus.wr && selRx;
    wire logic enabled = ctrl_ff[BIT_ENABLE];
    wire logic swoe = ctrl_ff[BIT_SWOE];
    wire logic irxm = ctrl_ff[BIT_IRXM];
    wire logic sclEdge = sclSync_ff != sclPrev_ff;
    wire logic isGcall = addrSeen && addrByte == GCALL_ADDR;
    wire logic rxEvent = enabled && irxm && rxByteDone;
    // a write to the rx-control register releases the held byte with the chosen response
    wire logic rxRelease = rxPending_ff && wrRx;
    wire logic [EV_W-1:0] events = {enabled && sclEdge, enabled && isGcall && ctrl_ff[BIT_GCALL], rxEvent};
    wire logic [CTRL_W-1:0] ctrlRead = {ctrl_ff[BIT_SWOE], sclSync_ff, ctrl_ff[BIT_SDAO:0]};

    wire logic [31:0] readMux =
        selCtrl ? {{(32-CTRL_W){1'b0}}, ctrlRead} :
        selStat ? {{(32-EV_W){1'b0}}, status_ff} :
        selIen ? {{(32-EV_W){1'b0}}, ien_ff} :
        selRx ? {{31{1'b0}}, rxPending_ff} : 32'h0000_0000;

    // software drives pins only when enabled and swoe set; 0 pulls low, 1 releases
    wire logic swSdaOe = !ctrl_ff[BIT_SDAO];
    wire logic swSclOe = !ctrl_ff[BIT_SCLO];
    wire i2ccw_pins_s nxtPins = !enabled ? i2ccw_pins_s'{default: 1'b0} :
        swoe ? i2ccw_pins_s'{sdaOut: 1'b0, sdaOe: swSdaOe, sclOut: 1'b0, sclOe: swSclOe} :
        i2ccw_pins_s'{sdaOut: 1'b0, sdaOe: ctlPins.sdaOe && !ctlPins.sdaOut,
          sclOut: 1'b0, sclOe: ctlPins.sclOe && !ctlPins.sclOut};

    // general call acknowledged only when enabled and bit 2 set; other addresses left to the controller
    wire logic nxtAddrAck = enabled && isGcall && ctrl_ff[BIT_GCALL];

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (wrCtrl)
        begin
            nxt_ctrl = {bus.wdata[BIT_SWOE], 1'b0, bus.wdata[BIT_SDAO:0]};
            nxt_ctrl[BIT_RSVD] = bus.wdata[BIT_RSVD];
        end
    end

    always_comb
    begin
        nxt_status = status_ff;
        if (wrClr)
        begin
            nxt_status = status_ff & ~bus.wdata[EV_W-1:0];
        end
        nxt_status = nxt_status | events; // set wins over clear
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl_ff <= CTRL_RESET;
            status_ff <= EV_RESET;
            ien_ff <= EV_RESET;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            status_ff <= nxt_status;
            if (wrIen)
            begin
                ien_ff <= bus.wdata[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sclMeta_ff <= 1'b1;
            sclSync_ff <= 1'b1;
            sclPrev_ff <= 1'b1;
            sdaMeta_ff <= 1'b1;
            sdaSync_ff <= 1'b1;
        end
        else
        begin
            sclMeta_ff <= sclIn;
            sclSync_ff <= sclMeta_ff;
            sclPrev_ff <= sclSync_ff;
            sdaMeta_ff <= sdaIn;
            sdaSync_ff <= sdaMeta_ff;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rdata_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            pins_ff <= '0;
            addrAck_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= bus.rd ? readMux : 32'h0000_0000;
            irq_ff <= |(nxt_status & ien_ff);
            pins_ff <= nxtPins;
            addrAck_ff <= nxtAddrAck;
        end
    end

    // interactive receive: hold the byte until software answers, then respond per bit 4
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rxPending_ff <= 1'b0;
            rxNack_ff <= 1'b0;
            rxRespValid_ff <= 1'b0;
        end
        else
        begin
            rxRespValid_ff <= rxRelease || (enabled && !irxm && rxByteDone);
            if (rxEvent)
            begin
                rxPending_ff <= 1'b1;
            end
            else if (rxRelease || !enabled)
            begin
                rxPending_ff <= 1'b0;
            end
            if (rxRelease)
            begin
                rxNack_ff <= ctrl_ff[BIT_IRACK];
            end
            else if (enabled && !irxm && rxByteDone)
            begin
                rxNack_ff <= 1'b0;
            end
        end
    end

    assign rdata = rdata_ff;
    assign irq = irq_ff;
    assign pins = pins_ff;
    assign addrAck = addrAck_ff;
    assign rxNack = rxNack_ff;
    assign rxRespValid = rxRespValid_ff;
    assign periphEnable = ctrl_ff[BIT_ENABLE];
    assign masterMode = ctrl_ff[BIT_MASTER];
    assign sclLevel = sclSync_ff;
    assign sdaLevel = sdaSync_ff;

    AST_SCL_READ: assert property (@(posedge clock) disable iff (reset)
        bus.rd && selCtrl |=> rdata[BIT_SCLIN] == $past(sclSync_ff))
        else $error("scl readback wrong");
    AST_SCL_SYNC: assert property (@(posedge clock) disable iff (reset)
        sclLevel == $past(sclMeta_ff))
        else $error("scl level not synchronised");
    AST_SCL_EDGE: assert property (@(posedge clock) disable iff (reset)
        enabled && sclEdge |=> status_ff[EV_SCLEDGE])
        else $error("scl edge event lost");
    AST_SDA_SYNC: assert property (@(posedge clock) disable iff (reset)
        sdaLevel == $past(sdaMeta_ff))
        else $error("sda level not synchronised");
    AST_SDA_SW: assert property (@(posedge clock) disable iff (reset)
        enabled && swoe |=> pins.sdaOe == !$past(ctrl_ff[BIT_SDAO]))
        else $error("sda software drive wrong");
    AST_SDA_HW: assert property (@(posedge clock) disable iff (reset)
        enabled && !swoe |=> pins.sdaOe == ($past(ctlPins.sdaOe) && !$past(ctlPins.sdaOut)))
        else $error("sda controller drive wrong");
    AST_SCL_SW: assert property (@(posedge clock) disable iff (reset)
        enabled && swoe |=> pins.sclOe == !$past(ctrl_ff[BIT_SCLO]))
        else $error("scl software drive wrong");
    AST_SCL_HW: assert property (@(posedge clock) disable iff (reset)
        enabled && !swoe |=> pins.sclOe == ($past(ctlPins.sclOe) && !$past(ctlPins.sclOut)))
        else $error("scl controller drive wrong");
    AST_RESP: assert property (@(posedge clock) disable iff (reset)
        rxRelease |=> rxRespValid && rxNack == $past(ctrl_ff[BIT_IRACK]))
        else $error("interactive response wrong");
    AST_IRACK_STORE: assert property (@(posedge clock) disable iff (reset)
        wrCtrl |=> ctrl_ff[BIT_IRACK] == $past(bus.wdata[BIT_IRACK]))
        else $error("response select not stored");
    AST_AUTO_ACK: assert property (@(posedge clock) disable iff (reset)
        enabled && !irxm && rxByteDone && !rxRelease |=> rxRespValid && !rxNack)
        else $error("plain receive not acknowledged");
    AST_RX_EVENT: assert property (@(posedge clock) disable iff (reset)
        rxEvent |=> status_ff[EV_RXBYTE] && rxPending_ff && !rxRespValid)
        else $error("receive event not raised");
    AST_IRXM_STORE: assert property (@(posedge clock) disable iff (reset)
        wrCtrl |=> irxm == $past(bus.wdata[BIT_IRXM]))
        else $error("interactive mode not stored");
    AST_RX_WAIT: assert property (@(posedge clock) disable iff (reset)
        enabled && irxm && !rxRelease |=> !rxRespValid)
        else $error("response sent before software answer");
    AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (reset)
        !$past(wrIen) |-> irq == |(status_ff & ien_ff))
        else $error("interrupt level wrong");
    AST_RX_CLEAR: assert property (@(posedge clock) disable iff (reset)
        wrClr && bus.wdata[EV_RXBYTE] && !rxEvent |=> !status_ff[EV_RXBYTE])
        else $error("receive event not cleared");
    AST_GCALL: assert property (@(posedge clock) disable iff (reset)
        addrSeen && addrByte == GCALL_ADDR && !ctrl_ff[BIT_GCALL] |=> !addrAck)
        else $error("general call acknowledged while off");
    AST_GCALL_ACK: assert property (@(posedge clock) disable iff (reset)
        enabled && isGcall && ctrl_ff[BIT_GCALL] |=> addrAck)
        else $error("general call not acknowledged");
    AST_ADDR_OTHER: assert property (@(posedge clock) disable iff (reset)
        addrSeen && addrByte != GCALL_ADDR |=> !addrAck)
        else $error("other address acknowledged");
    AST_ROLE: assert property (@(posedge clock) disable iff (reset)
        wrCtrl |=> masterMode == $past(bus.wdata[BIT_MASTER]))
        else $error("role not updated");
    AST_ROLE_HOLD: assert property (@(posedge clock) disable iff (reset)
        !wrCtrl |=> $stable(masterMode))
        else $error("role changed without write");
    AST_ENABLE: assert property (@(posedge clock) disable iff (reset)
        wrCtrl |=> periphEnable == $past(bus.wdata[BIT_ENABLE]))
        else $error("enable not updated");
    AST_ENABLE_HOLD: assert property (@(posedge clock) disable iff (reset)
        !wrCtrl |=> $stable(periphEnable))
        else $error("enable changed without write");
    AST_RESET_OUT: assert property (@(posedge clock) disable iff (reset)
        $past(reset) |-> !periphEnable && !masterMode && !pins.sdaOe && !pins.sclOe
            && !addrAck && !irq && !rxRespValid)
        else $error("outputs not at reset values");
    AST_SWOE_READ: assert property (@(posedge clock) disable iff (reset)
        bus.rd && selCtrl |=> rdata[BIT_SWOE] == $past(swoe))
        else $error("software output enable readback wrong");
    AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (reset)
        !pins.sdaOut && !pins.sclOut)
        else $error("pin driven high");
    AST_DISABLED: assert property (@(posedge clock) disable iff (reset)
        !enabled |=> !pins.sdaOe && !pins.sclOe && !addrAck)
        else $error("disabled peripheral active");
    AST_DIS_EVENTS: assert property (@(posedge clock) disable iff (reset)
        !enabled && !wrClr |=> $stable(status_ff))
        else $error("disabled peripheral raised an event");
    AST_DIS_PENDING: assert property (@(posedge clock) disable iff (reset)
        !enabled |=> !rxPending_ff)
        else $error("disabled peripheral holds a byte");
    AST_DIS_RESP: assert property (@(posedge clock) disable iff (reset)
        !enabled && !rxPending_ff |=> !rxRespValid)
        else $error("disabled peripheral responded");
    COV_BITBANG: cover property (@(posedge clock) disable iff (reset) enabled && swoe && pins.sclOe);
    COV_RX_NACK: cover property (@(posedge clock) disable iff (reset) rxRelease && ctrl_ff[BIT_IRACK]);
    COV_AUTO_ACK: cover property (@(posedge clock) disable iff (reset) rxRespValid && !irxm);
    COV_GCALL: cover property (@(posedge clock) disable iff (reset) addrAck);
    COV_IRQ: cover property (@(posedge clock) disable iff (reset) irq);
endmodule

// file: rtl/i2ccw_pkg.sv
// package for the i2c control word block: offsets, field positions, reset values, structs
// assumes a 32-bit register port with read data one cycle after the read strobe
package i2ccw_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CONTROL_MAIN = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_RX_CTRL = 8'h1c;
    // control word field positions
    localparam int BIT_ENABLE = 0;
    localparam int BIT_MASTER = 1;
    localparam int BIT_GCALL = 2;
    localparam int BIT_IRXM = 3;
    localparam int BIT_IRACK = 4;
    localparam int BIT_RSVD = 5;
    localparam int BIT_SCLO = 6;
    localparam int BIT_SDAO = 7;
    localparam int BIT_SCLIN = 8;
    localparam int BIT_SWOE = 9;
    localparam int CTRL_W = 10;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
    // interrupt event positions
    localparam int EV_RXBYTE = 0;
    localparam int EV_GCALL = 1;
    localparam int EV_SCLEDGE = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;
    localparam logic [7:0] GCALL_ADDR = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } i2ccw_bus_s;

    typedef struct packed {
        logic sdaOut;
        logic sdaOe;
        logic sclOut;
        logic sclOe;
    } i2ccw_pins_s;
endpackage

// file: test/i2ccw_bus_partner.sv
// far side of the i2c bus: pull-ups on both lines and a remote master clock
// assumes the device pins use the open-drain encoding of i2ccw_pins_s
module i2ccw_bus_partner
    import i2ccw_pkg::*;
(
    input wire i2ccw_pins_s pins, // device pin drive
    input wire logic runClk, // far side clocks scl
    input wire logic sdaLow, // far side pulls sda low
    output logic sclLine, // resolved scl level
    output logic sdaLine // resolved sda level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic farScl = 1'b1;
    initial
    begin
        forever
        begin
            #32;
            // 64 ns link clock, parked high outside frames
            farScl = runClk ? ~farScl : 1'b1;
        end
    end
    // wired-and of all pull-downs against the pull-ups
    assign sclLine = ~(pins.sclOe & ~pins.sclOut) & farScl;
    assign sdaLine = ~(pins.sdaOe & ~pins.sdaOut) & ~sdaLow;
endmodule

// file: test/tb_i2ccw_control_word.sv
// testbench for the i2c control word: register port tasks and pin checks
// assumes the bus partner resolves both lines with pull-ups
module tb_i2ccw_control_word
    import i2ccw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    i2ccw_bus_s bus = '0;
    i2ccw_pins_s ctlPins = '0;
    i2ccw_pins_s pins;
    logic rxByteDone = 1'b0;
    logic addrSeen = 1'b0;
    logic [7:0] addrByte = 8'h00;
    logic runClk = 1'b0;
    logic sdaLow = 1'b0;
    logic [31:0] rdata;
    logic sclLine, sdaLine, periphEnable, masterMode, addrAck;
    logic rxNack, rxRespValid, sclLevel, sdaLevel, irq;
    int badCount = 0;
    int comparisons = 0;

    i2ccw_control_word i2ccw_control_word_inst (.clock(clock), .reset(reset), .bus(bus), .rdata(rdata),
        .sclIn(sclLine), .sdaIn(sdaLine), .ctlPins(ctlPins), .rxByteDone(rxByteDone), .addrSeen(addrSeen),
        .addrByte(addrByte), .pins(pins), .periphEnable(periphEnable), .masterMode(masterMode),
        .addrAck(addrAck), .rxNack(rxNack), .rxRespValid(rxRespValid), .sclLevel(sclLevel),
        .sdaLevel(sdaLevel), .irq(irq));
    i2ccw_bus_partner i2ccw_bus_partner_inst (.pins(pins), .runClk(runClk), .sdaLow(sdaLow),
        .sclLine(sclLine), .sdaLine(sdaLine));

    initial
    begin
        forever #4 clock = ~clock;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic seeAddr(input logic [7:0] a, input logic exp);
        @(posedge clock);
        addrByte <= a;
        addrSeen <= 1'b1;
        @(posedge clock);
        addrSeen <= 1'b0;
        #1 chk(addrAck, exp);
    endtask

    task automatic waitScl(input logic lvl);
        int n;
        for (n = 0; n < 20 && sclLevel !== lvl; n++)
            @(posedge clock);
        chk(sclLevel, lvl);
        if (n == 20)
            stop_test();
    endtask

    initial
    begin
        repeat (50000) @(posedge clock);
        badCount++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        rd(OFF_CONTROL_MAIN, 32'h100);
        chk({periphEnable, masterMode, pins}, 6'h00);
        wr(OFF_CONTROL_MAIN, 32'h007);
        #1 chk({periphEnable, masterMode}, 2'b11);
        rd(OFF_CONTROL_MAIN, 32'h107);
        seeAddr(GCALL_ADDR, 1'b1);
        seeAddr(8'h42, 1'b0);
        wr(OFF_CONTROL_MAIN, 32'h003);
        seeAddr(GCALL_ADDR, 1'b0);
        wr(OFF_CONTROL_MAIN, 32'h004);
        seeAddr(GCALL_ADDR, 1'b0);
        // controller pulls both lines; disabled block must not pass it on
        @(posedge clock);
        ctlPins <= '{sdaOut: 1'b0, sdaOe: 1'b1, sclOut: 1'b0, sclOe: 1'b1};
        repeat (3) @(posedge clock);
        #1 chk(pins, 4'h0);
        wr(OFF_CONTROL_MAIN, 32'h0c1);
        @(posedge clock);
        #1 chk(pins, 4'h5);
        @(posedge clock);
        ctlPins <= '0;
        wr(OFF_CONTROL_MAIN, 32'h281);
        @(posedge clock);
        #1 chk(pins, 4'h1);
        waitScl(1'b0);
        rd(OFF_CONTROL_MAIN, 32'h281);
        wr(OFF_CONTROL_MAIN, 32'h241);
        @(posedge clock);
        #1 chk(pins, 4'h4);
        waitScl(1'b1);
        chk(sdaLevel, 1'b0);
        rd(OFF_CONTROL_MAIN, 32'h341);
        rd(OFF_IRQ_STATUS, 32'h6);
        wr(OFF_IRQ_CLEAR, 32'h6);
        wr(OFF_IRQ_ENABLE, 32'h1);
        for (int n = 0; n < 2; n++)
        begin
            wr(OFF_CONTROL_MAIN, 32'h009 | (n << 4));
            @(posedge clock);
            rxByteDone <= 1'b1;
            @(posedge clock);
            rxByteDone <= 1'b0;
            rd(OFF_IRQ_STATUS, 32'h1);
            chk(irq, 1'b1);
            rd(OFF_RX_CTRL, 32'h1);
            wr(OFF_RX_CTRL, 32'h0);
            #1 chk({rxRespValid, rxNack}, {1'b1, n[0]});
            wr(OFF_IRQ_CLEAR, 32'h1);
            @(posedge clock);
            #1 chk(irq, 1'b0);
        end
        rd(8'h40, 32'h0);
        rd(OFF_IRQ_CLEAR, 32'h0);
        wr(OFF_CONTROL_MAIN, 32'h001);
        @(posedge clock);
        rxByteDone <= 1'b1;
        @(posedge clock);
        rxByteDone <= 1'b0;
        #1 chk({rxRespValid, rxNack}, 2'b10);
        wr(OFF_IRQ_ENABLE, 32'h4);
        runClk <= 1'b1;
        sdaLow <= 1'b1;
        repeat (40) @(posedge clock);
        chk(sdaLevel, 1'b0);
        runClk <= 1'b0;
        sdaLow <= 1'b0;
        repeat (12) @(posedge clock);
        rd(OFF_IRQ_STATUS, 32'h4);
        chk(irq, 1'b1);
        stop_test();
    end
endmodule
